// ==== design/idsp_decode.sv ====
`timescale 1ns/1ps
// Functional notes
// R01 - Each enabled port decodes eight consecutive I/O addresses at its base.
// R02 - Four switch positions select a fixed pair of port bases.
// R03 - All switch positions off: neither port decodes anything.
// R04 - Second port enabled while its jumper is fitted.
// R05 - Second port disabled: only first port base answers.
// R06 - Each port's request routes to one supported ISA line.
// R07 - No line selected: no bus line driven for that port.
// R08 - Normal mode: port drives its own dedicated line actively.
// R09 - Shared mode: ports on one line do not contend.
// R10 - Integrator fits exactly one pull-down per shared line.
// R11 - Shared mode without pull-down cannot raise an interrupt.
// R12 - Each port's UART clock divides by 4, 2 or 1.
// R13 - Divide 4 gives 115.2K max, by 2 230.4K, by 1 460.8K.
// R14 - Each port's UART has programmable format and 32 byte FIFOs.
// R15 - Host uses 16 bit slot to reach lines 10, 11, 12, 15.
// R16 - DTE: drive TD, RTS, DTR; sample RD, DCD, DSR, CTS, RI.
// R17 - Shared mode drives line only while requesting, else releases.
// R18 - No port selection while DMA address enable is asserted.
module idsp_decode (
    // Clock, enable, reset
    input wire logic i_mclk,
    input wire logic i_ce,
    input wire logic i_sys_rst,
    // ISA I/O cycle
    input wire logic [idsp_pkg::ADDR_W-1:0] i_isa_addr,
    input wire logic i_isa_aen,
    input wire logic i_isa_ior_n,
    input wire logic i_isa_iow_n,
    // Straps
    input wire logic [idsp_pkg::SW_W-1:0] i_address_pair_select_switch,
    input wire logic i_second_port_enable_jumper,
    input wire logic [idsp_pkg::IRQ_SEL_W-1:0] i_first_port_irq_line_select,
    input wire logic [idsp_pkg::IRQ_SEL_W-1:0] i_second_port_irq_line_select,
    input wire logic [1:0] i_interrupt_sharing_mode_select,
    input wire logic [1:0] i_first_port_clock_divide_select,
    input wire logic [1:0] i_second_port_clock_divide_select,
    // UART side
    input wire logic [1:0] i_uart_irq,
    input wire logic [1:0] i_uart_ref_clk,
    output logic [1:0] o_uart_cs,
    output logic [2:0] o_uart_reg,
    output logic [1:0] o_uart_clk_en,
    // ISA interrupt lines, tri-state as two signals
    output logic [idsp_pkg::IRQ_W-1:0] o_isa_irq,
    output logic [idsp_pkg::IRQ_W-1:0] o_isa_irq_oe_n,
    // Line side, first then second port connector
    input wire logic [1:0] i_uart_td,
    input wire logic [1:0] i_uart_rts,
    input wire logic [1:0] i_uart_dtr,
    output logic [1:0] o_td,
    output logic [1:0] o_rts,
    output logic [1:0] o_dtr,
    input wire logic [1:0] i_rd,
    input wire logic [1:0] i_dcd,
    input wire logic [1:0] i_dsr,
    input wire logic [1:0] i_cts,
    input wire logic [1:0] i_ri,
    output logic [1:0] o_uart_rd,
    output logic [4:0] o_modem_status [0:1],
    // Glue register port
    input wire logic [2:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_irq
);

    // ****************************************
    // Address decode
    // ****************************************
    logic [idsp_pkg::ADDR_W-1:0] base1;
    logic [idsp_pkg::ADDR_W-1:0] base2;
    logic row_ok;
    logic port2_on;
    logic [1:0] hit;
    logic cycle;
    logic access_miss;
    logic cfg_force_off;

    // Table lookup of the base pair
    assign base1 = idsp_pkg::BASE1[i_address_pair_select_switch]; // see R02
    assign base2 = idsp_pkg::BASE2[i_address_pair_select_switch]; // see R02
    assign row_ok = idsp_pkg::ROW_VALID[i_address_pair_select_switch] && !cfg_force_off; // see R03
    assign port2_on = i_second_port_enable_jumper; // see R04
    assign cycle = !i_isa_aen && (!i_isa_ior_n || !i_isa_iow_n); // see R18

    // Eight-location window compare per port
    always_comb begin
        hit[0] = row_ok && cycle && ((i_isa_addr & idsp_pkg::BLOCK_MASK) == base1); // see R01
        hit[1] = row_ok && cycle && port2_on && ((i_isa_addr & idsp_pkg::BLOCK_MASK) == base2); // see R05
        // Port 1 wins an overlapping pair so only one UART drives the data bus
        if (hit[0]) begin
            hit[1] = 1'b0;
        end
    end

    assign o_uart_cs = hit;
    assign o_uart_reg = i_isa_addr[idsp_pkg::PORT_SPAN_BITS-3'h1:0];
    assign access_miss = cycle && !(|hit);

    // ****************************************
    // Interrupt routing
    // ****************************************
    logic [idsp_pkg::IRQ_SEL_W-1:0] irq_sel [0:1];
    assign irq_sel[0] = i_first_port_irq_line_select;
    assign irq_sel[1] = i_second_port_irq_line_select;

    // Drive or release each ISA line from the two ports
    always_comb begin
        o_isa_irq = '0;
        o_isa_irq_oe_n = '1;
        for (int p = 0; p < 2; p++) begin
            if (irq_sel[p] != idsp_pkg::IRQ_NONE && idsp_pkg::IRQ_SUPPORTED[irq_sel[p]]
                && (p == 0 || port2_on)) begin // see R06 R07
                if (!i_interrupt_sharing_mode_select[p]) begin
                    // Normal: totem-pole drive of the line at all times
                    o_isa_irq[irq_sel[p]] = i_uart_irq[p]; // see R08
                    o_isa_irq_oe_n[irq_sel[p]] = 1'b0;
                end else if (i_uart_irq[p]) begin
                    // Shared: only high is driven, pull-down gives idle low
                    o_isa_irq[irq_sel[p]] = 1'b1; // see R09 R17 R11
                    o_isa_irq_oe_n[irq_sel[p]] = 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Reference clock divide
    // ****************************************
    logic [1:0] div_cnt [0:1];
    logic [1:0] ref_q [0:1];
    logic [1:0] div_last [0:1];
    logic [1:0] div_sel [0:1];
    assign div_sel[0] = i_first_port_clock_divide_select;
    assign div_sel[1] = i_second_port_clock_divide_select;

    // Ratio selection per port
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            case (idsp_pkg::idsp_div_t'(div_sel[p]))
                idsp_pkg::IDSP_DIV4: div_last[p] = idsp_pkg::DIV4_LAST; // see R12 R13
                idsp_pkg::IDSP_DIV2: div_last[p] = idsp_pkg::DIV2_LAST; // see R12 R13
                idsp_pkg::IDSP_DIV1: div_last[p] = idsp_pkg::DIV1_LAST; // see R12 R13
                default: div_last[p] = idsp_pkg::DIV4_LAST;
            endcase
        end
    end

    // Count reference edges, one enable per divided period
    always_ff @(posedge i_mclk) begin
        for (int p = 0; p < 2; p++) begin
            if (i_sys_rst) begin
                ref_q[p] <= 2'h0;
                div_cnt[p] <= 2'h0;
                o_uart_clk_en[p] <= 1'b0;
            end else if (i_ce) begin
                ref_q[p] <= {ref_q[p][0], i_uart_ref_clk[p]};
                o_uart_clk_en[p] <= 1'b0;
                if (ref_q[p][0] && !ref_q[p][1]) begin
                    if (div_cnt[p] >= div_last[p]) begin
                        div_cnt[p] <= 2'h0;
                        o_uart_clk_en[p] <= 1'b1; // see R12
                    end else begin
                        div_cnt[p] <= div_cnt[p] + 2'h1;
                    end
                end
            end
        end
    end

    // ****************************************
    // Line side as DTE
    // ****************************************
    // Outputs registered, inputs registered and passed to the UART cores
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_td <= 2'h3;
            o_rts <= 2'h0;
            o_dtr <= 2'h0;
            o_uart_rd <= 2'h3;
            o_modem_status[0] <= 5'h00;
            o_modem_status[1] <= 5'h00;
        end else if (i_ce) begin
            o_td <= i_uart_td; // see R16
            o_rts <= i_uart_rts; // see R16
            o_dtr <= i_uart_dtr; // see R16
            o_uart_rd <= i_rd; // see R16
            for (int p = 0; p < 2; p++) begin
                o_modem_status[p] <= {i_dcd[p], i_dsr[p], i_cts[p], i_ri[p], i_rd[p]}; // see R16
            end
        end
    end

    // ****************************************
    // Glue status, mask and config registers
    // ****************************************
    logic [7:0] istat;
    logic [7:0] imask;
    logic [7:0] ev;
    logic mis_q;
    logic [1:0] uirq_q;

    // Events: decode miss (rising) and any UART request rising
    assign ev = {6'h00, |(i_uart_irq & ~uirq_q), access_miss && !mis_q};

    // Edge history of event sources
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mis_q <= 1'b0;
            uirq_q <= 2'h0;
        end else if (i_ce) begin
            mis_q <= access_miss;
            uirq_q <= i_uart_irq;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            istat <= 8'h00;
        end else if (i_ce) begin
            if (i_reg_wr && i_reg_addr == idsp_pkg::REG_ISTAT) begin
                istat <= ((istat & ~i_reg_wdata) | ev) & idsp_pkg::EV_BITS;
            end else begin
                istat <= (istat | ev) & idsp_pkg::EV_BITS;
            end
        end
    end

    // Mask and config writes
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            imask <= 8'h00;
            cfg_force_off <= 1'b0;
        end else if (i_ce && i_reg_wr) begin
            if (i_reg_addr == idsp_pkg::REG_IMASK) begin
                imask <= i_reg_wdata & idsp_pkg::EV_BITS;
            end
            if (i_reg_addr == idsp_pkg::REG_CFG) begin
                cfg_force_off <= i_reg_wdata[0];
            end
        end
    end

    // Read data, one cycle after the strobe, zero elsewhere
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_ce) begin
            o_reg_rdata <= 8'h00;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    idsp_pkg::REG_ISTAT: o_reg_rdata <= istat;
                    idsp_pkg::REG_IMASK: o_reg_rdata <= imask;
                    idsp_pkg::REG_CFG: o_reg_rdata <= {port2_on, row_ok, 5'h00, cfg_force_off};
                    // Read-only depth of each UART FIFO, same for receive and transmit
                    idsp_pkg::REG_DEPTH: o_reg_rdata <= 8'(idsp_pkg::FIFO_DEPTH); // see R14
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Level interrupt, high while an unmasked status bit is set
    assign o_irq = |(istat & imask);

    // ****************************************
    // Checks
    // ****************************************
    a_dma_no_select: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R18
        i_isa_aen |-> o_uart_cs == 2'h0) else $error("Port selected during DMA");
    a_off_no_decode: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R03
        i_address_pair_select_switch == idsp_pkg::SW_ALL_OFF |-> o_uart_cs == 2'h0)
        else $error("Decode with switches off");
    a_p2_disabled: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R05
        !i_second_port_enable_jumper |-> !o_uart_cs[1]) else $error("Port two decoded while off");
    a_p1_window: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R01
        o_uart_cs[0] |-> (i_isa_addr & idsp_pkg::BLOCK_MASK) == base1) else $error("Port one outside window");
    a_no_line_drive: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R07
        i_first_port_irq_line_select == idsp_pkg::IRQ_NONE && i_second_port_irq_line_select == idsp_pkg::IRQ_NONE
        |-> o_isa_irq_oe_n == '1) else $error("Line driven with none selected");
    a_shared_release: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R17
        (i_interrupt_sharing_mode_select == 2'h3 && i_uart_irq == 2'h0) |-> o_isa_irq_oe_n == '1)
        else $error("Shared line held while idle");
    a_normal_drive: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R08
        (!i_interrupt_sharing_mode_select[0] && idsp_pkg::IRQ_SUPPORTED[i_first_port_irq_line_select])
        |-> !o_isa_irq_oe_n[i_first_port_irq_line_select]) else $error("Normal line not driven");
    a_unsupported_line: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // see R06
        (o_isa_irq_oe_n | idsp_pkg::IRQ_SUPPORTED) == '1) else $error("Unsupported line driven");
    a_div1_rate: assert property (@(posedge i_mclk) disable iff (i_sys_rst || !i_ce) // see R12
        (i_first_port_clock_divide_select == 2'h2 && ref_q[0] == 2'h1) |=> o_uart_clk_en[0])
        else $error("Divide by one missed edge");
    a_dte_out: assert property (@(posedge i_mclk) disable iff (i_sys_rst || !i_ce) // see R16
        1'b1 |=> o_td == $past(i_uart_td)) else $error("Transmit data not passed");

endmodule

// ==== design/idsp_pkg.sv ====
package idsp_pkg;

    // ****************************************
    // Address decode
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int SW_W = 4;
    localparam logic [2:0] PORT_SPAN_BITS = 3'h3;
    localparam logic [ADDR_W-1:0] BLOCK_MASK = 16'hfff8;

    // Switch code 4'b1111 is all positions off; bit 3 is position 1, on = 0
    localparam logic [SW_W-1:0] SW_ALL_OFF = 4'hf;

    // Base pair table indexed by switch code (on = 0)
    localparam logic [ADDR_W-1:0] BASE1 [0:15] = '{
        16'h0000, 16'h03f8, 16'h03e8, 16'h02f8,
        16'h02f8, 16'h3220, 16'h4220, 16'h5220,
        16'h5220, 16'h0280, 16'h0300, 16'h0310,
        16'h0280, 16'h0290, 16'h0300, 16'h0000};
    localparam logic [ADDR_W-1:0] BASE2 [0:15] = '{
        16'h0000, 16'h02f8, 16'h02e8, 16'h02e8,
        16'h03e8, 16'h3228, 16'h4228, 16'h5228,
        16'h4220, 16'h0290, 16'h0308, 16'h0318,
        16'h0288, 16'h0298, 16'h0280, 16'h0000};
    localparam logic [15:0] ROW_VALID = 16'h7ffe;

    // ****************************************
    // Interrupt lines
    // ****************************************
    localparam int IRQ_W = 16;
    localparam logic [IRQ_W-1:0] IRQ_SUPPORTED = 16'h9cbc;
    localparam int IRQ_SEL_W = 4;
    localparam logic [IRQ_SEL_W-1:0] IRQ_NONE = 4'h0;

    // ****************************************
    // Clock divide
    // ****************************************
    typedef enum logic [1:0] {IDSP_DIV4, IDSP_DIV2, IDSP_DIV1, IDSP_DIVX} idsp_div_t;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV1_LAST = 2'h0;

    // ****************************************
    // UART capacity
    // ****************************************
    localparam int FIFO_DEPTH = 32;

    // ****************************************
    // Bus
    // ****************************************
    localparam logic [2:0] REG_ISTAT = 3'h0;
    localparam logic [2:0] REG_IMASK = 3'h1;
    localparam logic [2:0] REG_CFG = 3'h2;
    localparam logic [2:0] REG_DEPTH = 3'h3;
    localparam logic [7:0] EV_BITS = 8'h03;

endpackage

// ==== dv/idsp_host_model.sv ====
`timescale 1ns/1ps
// ********
// ISA host seen from the card
// ********
module idsp_host_model (
    // Clock
    input wire logic i_mclk,
    // Card interrupt lines and the pull-downs fitted on them
    input wire logic [15:0] i_isa_irq,
    input wire logic [15:0] i_isa_irq_oe_n,
    input wire logic [15:0] i_pull_down,
    output logic [15:0] o_irq_level,
    // I/O cycle driven by the processor
    output logic [15:0] o_isa_addr,
    output logic o_isa_aen,
    output logic o_isa_ior_n,
    output logic o_isa_iow_n
);
    logic [15:0] last_drv = 16'h0000;
    initial begin
        o_isa_addr = 16'h0000;
        o_isa_aen = 1'b0;
        o_isa_ior_n = 1'b1;
        o_isa_iow_n = 1'b1;
    end
    // Released line sinks to its one pull-down, else drifts away from the last level
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            o_irq_level[i] = !i_isa_irq_oe_n[i] ? i_isa_irq[i] : (i_pull_down[i] ? 1'b0 : ~last_drv[i]);
        end
    end
    // Last level that some driver put on each line
    always @(posedge i_mclk) last_drv <= (~i_isa_irq_oe_n & i_isa_irq) | (i_isa_irq_oe_n & last_drv);
    // Processor cycle or DMA cycle with address enable high
    task automatic io_set(input logic [15:0] a, input logic aen, input logic wr);
        o_isa_addr <= a;
        o_isa_aen <= aen;
        o_isa_ior_n <= wr;
        o_isa_iow_n <= !wr;
    endtask
    // Idle bus: strobes off, address lines left changing
    task automatic io_idle();
        o_isa_ior_n <= 1'b1;
        o_isa_iow_n <= 1'b1;
        o_isa_aen <= 1'b0;
        o_isa_addr <= ~o_isa_addr;
    endtask
endmodule

// ==== dv/isa_dual_serial_port_decode_tb.sv ====
`timescale 1ns/1ps
module isa_dual_serial_port_decode_tb;
    // ********
    // Signals
    // ********
    logic i_mclk = 1'b0, i_ce = 1'b1, i_sys_rst = 1'b1, i_isa_aen, i_isa_ior_n, i_isa_iow_n;
    logic [15:0] i_isa_addr, o_isa_irq, o_isa_irq_oe_n, irq_level, b1, b2, pull_down = 16'h0000;
    logic [3:0] i_address_pair_select_switch = 4'h1;
    logic [3:0] i_first_port_irq_line_select = 4'h0, i_second_port_irq_line_select = 4'h0;
    logic [1:0] i_interrupt_sharing_mode_select = 2'h0, i_first_port_clock_divide_select = 2'h0;
    logic [1:0] i_second_port_clock_divide_select = 2'h0, i_uart_irq = 2'h0, i_uart_ref_clk = 2'h0;
    logic [1:0] o_uart_cs, o_uart_clk_en, i_uart_td = 2'h3, i_uart_rts = 2'h0, i_uart_dtr = 2'h0;
    logic [1:0] o_td, o_rts, o_dtr, o_uart_rd, i_rd = 2'h3, i_dcd = 2'h0, i_dsr = 2'h0;
    logic [1:0] i_cts = 2'h0, i_ri = 2'h0;
    logic [2:0] o_uart_reg, i_reg_addr = 3'h0;
    logic [4:0] o_modem_status [0:1];
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
    logic i_second_port_enable_jumper = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, o_irq, foff = 1'b0;
    int err_total = 0, n_tests = 0, refc = 0, c0, c1, pulses [0:1] = '{0, 0};
    localparam logic [15:0] EXP_B1 [0:15] = '{16'h0000, 16'h03f8, 16'h03e8, 16'h02f8, 16'h02f8, 16'h3220,
        16'h4220, 16'h5220, 16'h5220, 16'h0280, 16'h0300, 16'h0310, 16'h0280, 16'h0290, 16'h0300, 16'h0000};
    localparam logic [15:0] EXP_B2 [0:15] = '{16'h0000, 16'h02f8, 16'h02e8, 16'h02e8, 16'h03e8, 16'h3228,
        16'h4228, 16'h5228, 16'h4220, 16'h0290, 16'h0308, 16'h0318, 16'h0288, 16'h0298, 16'h0280, 16'h0000};
    localparam int LINES [0:8] = '{2, 3, 4, 5, 7, 10, 11, 12, 15};
    localparam logic [15:0] OFS [0:4] = '{16'h0000, 16'h0007, 16'h0003, 16'hffff, 16'h0008};

    idsp_decode dut_u (
        .i_mclk(i_mclk), .i_ce(i_ce), .i_sys_rst(i_sys_rst),
        .i_isa_addr(i_isa_addr), .i_isa_aen(i_isa_aen), .i_isa_ior_n(i_isa_ior_n), .i_isa_iow_n(i_isa_iow_n),
        .i_address_pair_select_switch(i_address_pair_select_switch),
        .i_second_port_enable_jumper(i_second_port_enable_jumper),
        .i_first_port_irq_line_select(i_first_port_irq_line_select),
        .i_second_port_irq_line_select(i_second_port_irq_line_select),
        .i_interrupt_sharing_mode_select(i_interrupt_sharing_mode_select),
        .i_first_port_clock_divide_select(i_first_port_clock_divide_select),
        .i_second_port_clock_divide_select(i_second_port_clock_divide_select),
        .i_uart_irq(i_uart_irq), .i_uart_ref_clk(i_uart_ref_clk), .o_uart_cs(o_uart_cs), .o_uart_reg(o_uart_reg),
        .o_uart_clk_en(o_uart_clk_en), .o_isa_irq(o_isa_irq), .o_isa_irq_oe_n(o_isa_irq_oe_n),
        .i_uart_td(i_uart_td), .i_uart_rts(i_uart_rts), .i_uart_dtr(i_uart_dtr), .o_td(o_td), .o_rts(o_rts),
        .o_dtr(o_dtr), .i_rd(i_rd), .i_dcd(i_dcd), .i_dsr(i_dsr), .i_cts(i_cts), .i_ri(i_ri),
        .o_uart_rd(o_uart_rd), .o_modem_status(o_modem_status), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_irq(o_irq));
    idsp_host_model host_u (.i_mclk(i_mclk), .i_isa_irq(o_isa_irq), .i_isa_irq_oe_n(o_isa_irq_oe_n),
        .i_pull_down(pull_down), .o_irq_level(irq_level), .o_isa_addr(i_isa_addr), .o_isa_aen(i_isa_aen),
        .o_isa_ior_n(i_isa_ior_n), .o_isa_iow_n(i_isa_iow_n));

    // ********
    // Clocks and counters
    // ********
    initial forever #5 i_mclk = ~i_mclk;
    // Reference clock of six cycles and divided pulse counts
    always @(posedge i_mclk) begin
        refc <= (refc + 1) % 6;
        i_uart_ref_clk <= {2{refc < 3}};
        for (int p = 0; p < 2; p++) begin
            if (o_uart_clk_en[p] === 1'b1) pulses[p] <= pulses[p] + 1;
        end
    end

    // ********
    // Tasks
    // ********
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        @(posedge i_mclk);
        chk("reg_rdata", {8'h00, e}, {8'h00, o_reg_rdata});
    endtask
    function automatic logic [1:0] exp_cs(input logic [15:0] a, input logic aen);
        logic [15:0] x1, x2;
        x1 = EXP_B1[i_address_pair_select_switch];
        x2 = EXP_B2[i_address_pair_select_switch];
        if (aen || foff) return 2'h0;
        if (x1 != 16'h0000 && (a & 16'hfff8) == x1) return 2'h1;
        if (x2 != 16'h0000 && i_second_port_enable_jumper && (a & 16'hfff8) == x2) return 2'h2;
        return 2'h0;
    endfunction
    task automatic io(input logic [15:0] a, input logic aen, input logic w);
        logic [1:0] e;
        e = exp_cs(a, aen);
        host_u.io_set(a, aen, w);
        @(posedge i_mclk);
        chk("uart_cs", {14'h0, e}, {14'h0, o_uart_cs});
        if (e != 2'h0) chk("uart_reg", {13'h0, a[2:0]}, {13'h0, o_uart_reg});
        host_u.io_idle();
        @(posedge i_mclk);
    endtask
    task automatic irq_chk(input logic [15:0] eoe, input logic [15:0] ev);
        repeat (2) @(posedge i_mclk);
        chk("irq_oe_n", eoe, o_isa_irq_oe_n);
        chk("irq_value", ev & ~eoe, o_isa_irq & ~eoe);
    endtask
    function automatic int dv(input int code);
        return (code == 1) ? 2 : ((code == 2) ? 1 : 4);
    endfunction
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        #200000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h1, 8'h00);
        rd_chk(3'h2, 8'hc0);
        // Every switch row, second port fitted and removed
        for (int c = 0; c < 16; c++) begin
            for (int j = 0; j < 2; j++) begin
                i_address_pair_select_switch <= 4'(c);
                i_second_port_enable_jumper <= j[0];
                @(posedge i_mclk);
                b1 = EXP_B1[c];
                b2 = EXP_B2[c];
                for (int k = 0; k < 5; k++) begin
                    io(b1 + OFS[k], k == 2, k[0]);
                    io(b2 + OFS[k], 1'b0, k[1]);
                end
            end
        end
        i_address_pair_select_switch <= 4'h1;
        i_second_port_enable_jumper <= 1'b1;
        // Status, mask, interrupt output, unmapped place, force-off
        wr(3'h0, 8'hff);
        wr(3'h1, 8'h01);
        io(16'h0100, 1'b0, 1'b0);
        rd_chk(3'h0, 8'h01);
        chk("irq", 16'h0001, {15'h0, o_irq});
        wr(3'h0, 8'h01);
        chk("irq", 16'h0000, {15'h0, o_irq});
        wr(3'h1, 8'h00);
        io(16'h0100, 1'b0, 1'b1);
        rd_chk(3'h0, 8'h01);
        chk("irq", 16'h0000, {15'h0, o_irq});
        wr(3'h4, 8'hff);
        rd_chk(3'h4, 8'h00);
        rd_chk(3'h3, 8'h20);
        wr(3'h2, 8'h01);
        foff = 1'b1;
        rd_chk(3'h2, 8'h81);
        io(16'h03f8, 1'b0, 1'b0);
        wr(3'h2, 8'h00);
        foff = 1'b0;
        io(16'h03f8, 1'b0, 1'b0);
        wr(3'h0, 8'hff);
        wr(3'h1, 8'h02);
        // Clock enable low: a mask write must not land
        i_ce <= 1'b0;
        wr(3'h1, 8'h03);
        i_ce <= 1'b1;
        rd_chk(3'h1, 8'h02);
        // Normal mode on every supported line
        for (int i = 0; i < 9; i++) begin
            i_first_port_irq_line_select <= 4'(LINES[i]);
            i_uart_irq <= 2'h1;
            irq_chk(~(16'h0001 << LINES[i]), 16'h0001 << LINES[i]);
            i_uart_irq <= 2'h0;
            irq_chk(~(16'h0001 << LINES[i]), 16'h0000);
        end
        rd_chk(3'h0, 8'h02);
        chk("irq", 16'h0001, {15'h0, o_irq});
        i_first_port_irq_line_select <= 4'h6;
        irq_chk(16'hffff, 16'h0000);
        i_first_port_irq_line_select <= 4'h3;
        i_second_port_irq_line_select <= 4'hb;
        i_uart_irq <= 2'h2;
        irq_chk(16'hf7f7, 16'h0800);
        i_second_port_enable_jumper <= 1'b0;
        irq_chk(16'hfff7, 16'h0000);
        i_second_port_enable_jumper <= 1'b1;
        i_first_port_irq_line_select <= 4'h0;
        irq_chk(16'hf7ff, 16'h0800);
        // Both ports shared on one line with a single pull-down
        i_first_port_irq_line_select <= 4'h5;
        i_second_port_irq_line_select <= 4'h5;
        i_interrupt_sharing_mode_select <= 2'h3;
        pull_down <= 16'h0020;
        i_uart_irq <= 2'h0;
        irq_chk(16'hffff, 16'h0000);
        chk("irq_line", 16'h0000, {15'h0, irq_level[5]});
        for (int r = 1; r < 4; r++) begin
            i_uart_irq <= 2'(r);
            irq_chk(16'hffdf, 16'h0020);
            chk("irq_line", 16'h0001, {15'h0, irq_level[5]});
        end
        // Line side copies in both directions
        for (int k = 1; k < 3; k++) begin
            {i_uart_td, i_uart_rts, i_uart_dtr} <= {2'(k), ~2'(k), 2'(k)};
            {i_rd, i_dcd, i_dsr, i_cts, i_ri} <= {2'(k), ~2'(k), 2'(k), ~2'(k), 2'(k)};
            repeat (2) @(posedge i_mclk);
            chk("line_out", {10'h0, 2'(k), ~2'(k), 2'(k)}, {10'h0, o_td, o_rts, o_dtr});
            chk("modem", {6'h0, !k[1], k[1], !k[1], k[1], k[1], !k[0], k[0], !k[0], k[0], k[0]},
                {6'h0, o_modem_status[1], o_modem_status[0]});
            chk("uart_rd", {14'h0, 2'(k)}, {14'h0, o_uart_rd});
        end
        // Each divide code on both ports over sixteen reference periods
        for (int d = 0; d < 4; d++) begin
            i_first_port_clock_divide_select <= 2'(d);
            i_second_port_clock_divide_select <= 2'(3 - d);
            repeat (40) @(posedge i_mclk);
            c0 = pulses[0];
            c1 = pulses[1];
            repeat (96) @(posedge i_mclk);
            chk("div_1", 16'(16 / dv(d)), 16'(pulses[0] - c0));
            chk("div_2", 16'(16 / dv(3 - d)), 16'(pulses[1] - c1));
        end
        summarize();
    end
endmodule
